// ==== hw/tds_defs.svh ====
// Offsets, field positions, reset values and timing counts of the descriptor scheduler.
`ifndef TDS_DEFS_SVH
`define TDS_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define TDS_REG_CTRL       8'h00
`define TDS_REG_STATUS     8'h04
`define TDS_REG_DONE_BASE  8'h10
`define TDS_REG_SKIP_BASE  8'h20
`define TDS_REG_LAST_BASE  8'h30
`define TDS_REG_OR_BASE    8'h40
`define TDS_REG_AND_BASE   8'h50

// ------------------------------------------------------------
// Control fields and reset values
// ------------------------------------------------------------
`define TDS_CTRL_EN_BIT    0
`define TDS_CTRL_LAT_LSB   4
`define TDS_CTRL_LAT_MSB   11
`define TDS_MAP_RESET      32'h0000_0000
`define TDS_LAT_RESET      8'h01

// ------------------------------------------------------------
// Descriptor memory layout, word addresses
// ------------------------------------------------------------
`define TDS_ISO_BASE       12'h000
`define TDS_INTL_BASE      12'h100
`define TDS_ATL_BASE       12'h200
`define TDS_WORD_VALID     3'h0
`define TDS_WORD_STATUS    3'h3
`define TDS_WORD_LINK      3'h4
`define TDS_VALID_BIT      0
`define TDS_ACTIVE_BIT     31
`define TDS_BABBLE_BIT     29
`define TDS_JUMP_BIT       5
`define TDS_NEXT_MSB       4
`define TDS_NEXT_LSB       0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TDS_UFRAME_NS      125000
`define TDS_CLK_NS         40
`define TDS_UFRAME_CYC     (`TDS_UFRAME_NS / `TDS_CLK_NS)

`endif

// ==== hw/tds_pkg.sv ====
// Types shared by the descriptor scheduler modules.
package tds_pkg;

   typedef enum logic [1:0] {
      TDS_LIST_ISO,
      TDS_LIST_INTL,
      TDS_LIST_ATL
   } tds_list_t;

   typedef enum logic [3:0] {
      TDS_IDLE,
      TDS_SKIPCHK,
      TDS_RD_VALID,
      TDS_RD_STATUS,
      TDS_RD_LINK,
      TDS_DECIDE,
      TDS_EXEC,
      TDS_WB_STATUS,
      TDS_WB_VALID,
      TDS_ADVANCE
   } tds_state_t;

endpackage

// ==== hw/tds_irq_group.sv ====
// Grouping of one list's done map through its AND and OR masks.
`timescale 1ns/1ps
module tds_irq_group
   import tds_pkg::*;
#(
   parameter int WIDTH = 32
)(
   input  wire logic [WIDTH-1:0] done_map,
   input  wire logic [WIDTH-1:0] and_mask,
   input  wire logic [WIDTH-1:0] or_mask,
   output logic                  hit
);

   // Any masked descriptor done, or every descriptor of a non-empty AND group done.
   assign hit = (|(done_map & or_mask)) |
                ((|and_mask) && ((done_map & and_mask) == and_mask));

endmodule // tds_irq_group

// ==== hw/tds_scheduler.sv ====
// Transfer descriptor scheduler: walks three descriptor lists and reports completion.
//
// Summary of operation
// - Up to 32 descriptors in each of the isochronous, interrupt and async lists.
// - A pass runs the isochronous list, then the interrupt list, then async.
// - Async carries control and bulk, the others interrupt and isochronous transfers.
// - A descriptor is complete when its done bit is set; masks group completions.
// - Four sources: isochronous, interrupt list, async, start of frame.
// - Isochronous, interrupt list and async reporting waits a programmable number of 125 us microframes.
// - Each list is walked upward from index 0 in descriptor order, honouring skip, and the final marker unless a jump passes it.
// - A transaction runs only for a descriptor that is active and not done.
// - A jump continues walking at the index in bits 4 to 0 of word 4.
// - Jumps only go forward; software never points a descriptor at itself.
// - A skipped descriptor is ignored and the following one is taken.
// - A skipped descriptor's jump pointer is ignored as well.
// - Word 4 bit 5 selects stepping by one or jumping to the pointer.
// - Hardware clears the active flag when it finishes a descriptor.
// - On babble set the babble flag and clear active and valid.
// - AND and OR masks are 32-bit per-descriptor maps reset to zero.
`timescale 1ns/1ps
`include "tds_defs.svh"
module tds_scheduler
   import tds_pkg::*;
#(
   parameter int DESC_NUM = 32
)(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic      [11:0] mem_addr,
   output logic      [31:0] mem_wdata,
   input  wire logic [31:0] mem_rdata,
   output logic             xact_start,
   output logic      [1:0]  xact_list,
   output logic      [4:0]  xact_index,
   input  wire logic        xact_done,
   input  wire logic        xact_babble,
   output logic             iso_irq,
   output logic             intl_irq,
   output logic             async_irq,
   output logic             sof_irq
);

   if (DESC_NUM < 2 || DESC_NUM > 32)
   begin : g_check
      $error("DESC_NUM must lie between 2 and 32.");
   end

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   function automatic logic [1:0] list_of(input logic [7:0] a);
      list_of = a[3:2];
   endfunction

   function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
      in_bank = (a[7:4] == base[7:4]) && (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
   endfunction

   logic [31:0] done_q [3];
   logic [31:0] skip_q [3];
   logic [31:0] or_q   [3];
   logic [31:0] and_q  [3];
   logic [4:0]  last_q [3];
   logic        en_q;
   logic [7:0]  lat_q;
   logic [31:0] set_done;
   logic [1:0]  set_list;

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         en_q  <= 1'b0;
         lat_q <= `TDS_LAT_RESET;
      end
      else if (reg_wr && reg_addr == `TDS_REG_CTRL)
      begin
         en_q  <= reg_wdata[`TDS_CTRL_EN_BIT];
         lat_q <= reg_wdata[`TDS_CTRL_LAT_MSB:`TDS_CTRL_LAT_LSB];
      end
   end

   for (genvar l = 0; l < 3; l++)
   begin : g_bank
      always_ff @(posedge ref_clk)
      begin
         if (reset)
         begin
            skip_q[l] <= `TDS_MAP_RESET;
            or_q[l]   <= `TDS_MAP_RESET;
            and_q[l]  <= `TDS_MAP_RESET;
            last_q[l] <= 5'(DESC_NUM - 1);
         end
         else if (reg_wr && list_of(reg_addr) == 2'(l))
         begin
            if (in_bank(reg_addr, `TDS_REG_SKIP_BASE))
               skip_q[l] <= reg_wdata;
            if (in_bank(reg_addr, `TDS_REG_OR_BASE))
               or_q[l] <= reg_wdata;
            if (in_bank(reg_addr, `TDS_REG_AND_BASE))
               and_q[l] <= reg_wdata;
            if (in_bank(reg_addr, `TDS_REG_LAST_BASE))
               last_q[l] <= reg_wdata[4:0];
         end
      end

      // Done bits are cleared by writing ones; a completion in the same cycle wins.
      always_ff @(posedge ref_clk)
      begin
         if (reset)
            done_q[l] <= `TDS_MAP_RESET;
         else
            done_q[l] <= (done_q[l] & ~((reg_wr && list_of(reg_addr) == 2'(l) &&
                          in_bank(reg_addr, `TDS_REG_DONE_BASE)) ? reg_wdata : 32'h0000_0000))
                         | ((set_list == 2'(l)) ? set_done : 32'h0000_0000);
      end
   end

   // ------------------------------------------------------------
   // Walker state
   // ------------------------------------------------------------
   tds_state_t  state_q;
   tds_list_t   list_q;
   logic [4:0]  idx_q;
   logic [31:0] valid_w_q;
   logic [31:0] status_w_q;
   logic [31:0] link_w_q;
   logic        babble_q;
   logic        tick;
   logic [11:0] base;
   logic [5:0]  step_idx;
   logic [4:0]  next_idx;
   logic        list_end;

   always_comb
   begin
      case (list_q)
         TDS_LIST_ISO:  base = `TDS_ISO_BASE;
         TDS_LIST_INTL: base = `TDS_INTL_BASE;
         default:       base = `TDS_ATL_BASE;
      endcase
   end

   // Jump only when selected, forward and taken from a descriptor that was not skipped.
   always_comb
   begin
      step_idx = {1'b0, idx_q} + 6'h01;
      if (link_w_q[`TDS_JUMP_BIT] &&
          link_w_q[`TDS_NEXT_MSB:`TDS_NEXT_LSB] > idx_q)
         next_idx = link_w_q[`TDS_NEXT_MSB:`TDS_NEXT_LSB];
      else
         next_idx = step_idx[4:0];
   end

   assign list_end = (idx_q == last_q[list_q]) || (idx_q == 5'(DESC_NUM - 1));

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_q    <= TDS_IDLE;
         list_q     <= TDS_LIST_ISO;
         idx_q      <= 5'h00;
         valid_w_q  <= 32'h0000_0000;
         status_w_q <= 32'h0000_0000;
         link_w_q   <= 32'h0000_0000;
         babble_q   <= 1'b0;
      end
      else
      begin
         case (state_q)
            TDS_IDLE:
               if (en_q && tick)
               begin
                  list_q  <= TDS_LIST_ISO;
                  idx_q   <= 5'h00;
                  state_q <= TDS_SKIPCHK;
               end
            TDS_SKIPCHK:
            begin
               link_w_q <= 32'h0000_0000;
               if (skip_q[list_q][idx_q])
                  state_q <= TDS_ADVANCE;
               else
                  state_q <= TDS_RD_VALID;
            end
            TDS_RD_VALID:
               state_q <= TDS_RD_STATUS;
            TDS_RD_STATUS:
            begin
               valid_w_q <= mem_rdata;
               state_q   <= TDS_RD_LINK;
            end
            TDS_RD_LINK:
            begin
               status_w_q <= mem_rdata;
               state_q    <= TDS_DECIDE;
            end
            TDS_DECIDE:
            begin
               link_w_q <= mem_rdata;
               if (status_w_q[`TDS_ACTIVE_BIT] && !done_q[list_q][idx_q])
                  state_q <= TDS_EXEC;
               else
                  state_q <= TDS_ADVANCE;
            end
            TDS_EXEC:
               if (xact_done)
               begin
                  babble_q <= xact_babble;
                  state_q  <= TDS_WB_STATUS;
               end
            TDS_WB_STATUS:
               state_q <= babble_q ? TDS_WB_VALID : TDS_ADVANCE;
            TDS_WB_VALID:
               state_q <= TDS_ADVANCE;
            TDS_ADVANCE:
               if (list_end)
               begin
                  idx_q <= 5'h00;
                  case (list_q)
                     TDS_LIST_ISO:  list_q <= TDS_LIST_INTL;
                     TDS_LIST_INTL: list_q <= TDS_LIST_ATL;
                     default:       list_q <= TDS_LIST_ISO;
                  endcase
                  state_q <= (list_q == TDS_LIST_ATL) ? TDS_IDLE : TDS_SKIPCHK;
               end
               else
               begin
                  idx_q   <= next_idx;
                  state_q <= TDS_SKIPCHK;
               end
            default:
               state_q <= TDS_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Memory and transaction ports
   // ------------------------------------------------------------
   always_comb
   begin
      mem_rd    = 1'b0;
      mem_wr    = 1'b0;
      mem_addr  = base;
      mem_wdata = 32'h0000_0000;
      case (state_q)
         TDS_RD_VALID:
         begin
            mem_rd   = 1'b1;
            mem_addr = base + {4'h0, idx_q, `TDS_WORD_VALID};
         end
         TDS_RD_STATUS:
         begin
            mem_rd   = 1'b1;
            mem_addr = base + {4'h0, idx_q, `TDS_WORD_STATUS};
         end
         TDS_RD_LINK:
         begin
            mem_rd   = 1'b1;
            mem_addr = base + {4'h0, idx_q, `TDS_WORD_LINK};
         end
         TDS_WB_STATUS:
         begin
            mem_wr    = 1'b1;
            mem_addr  = base + {4'h0, idx_q, `TDS_WORD_STATUS};
            mem_wdata = status_w_q;
            mem_wdata[`TDS_ACTIVE_BIT] = 1'b0;
            mem_wdata[`TDS_BABBLE_BIT] = status_w_q[`TDS_BABBLE_BIT] | babble_q;
         end
         TDS_WB_VALID:
         begin
            mem_wr    = 1'b1;
            mem_addr  = base + {4'h0, idx_q, `TDS_WORD_VALID};
            mem_wdata = valid_w_q;
            mem_wdata[`TDS_VALID_BIT] = 1'b0;
         end
         default:
         begin
            mem_addr = base + {4'h0, idx_q, 3'h0};
         end
      endcase
   end

   assign xact_start = (state_q == TDS_DECIDE) && status_w_q[`TDS_ACTIVE_BIT] &&
                       !done_q[list_q][idx_q];
   assign xact_list  = list_q;
   assign xact_index = idx_q;
   assign set_list   = list_q;
   assign set_done   = (state_q == TDS_WB_STATUS) ? (32'h0000_0001 << idx_q) : 32'h0000_0000;

   // ------------------------------------------------------------
   // Microframe timing and interrupt sources
   // ------------------------------------------------------------
   logic [11:0] uf_cnt_q;
   logic [7:0]  lat_cnt_q;
   logic        report;
   logic [2:0]  hit;

   assign tick   = (uf_cnt_q == 12'(`TDS_UFRAME_CYC - 1));
   assign report = tick && (lat_cnt_q + 8'h01 >= lat_q);

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         uf_cnt_q <= 12'h000;
      else
         uf_cnt_q <= tick ? 12'h000 : uf_cnt_q + 12'h001;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         lat_cnt_q <= 8'h00;
      else if (report)
         lat_cnt_q <= 8'h00;
      else if (tick)
         lat_cnt_q <= lat_cnt_q + 8'h01;
   end

   for (genvar g = 0; g < 3; g++)
   begin : g_group
      tds_irq_group #(
         .WIDTH (32)
      ) u_group (
         .done_map (done_q[g]),
         .and_mask (and_q[g]),
         .or_mask  (or_q[g]),
         .hit      (hit[g])
      );
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         iso_irq   <= 1'b0;
         intl_irq  <= 1'b0;
         async_irq <= 1'b0;
         sof_irq   <= 1'b0;
      end
      else
      begin
         sof_irq <= tick;
         if (report)
         begin
            iso_irq   <= hit[0];
            intl_irq  <= hit[1];
            async_irq <= hit[2];
         end
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
      begin
         reg_rdata <= 32'h0000_0000;
         if (reg_addr == `TDS_REG_CTRL)
            reg_rdata <= {20'h00000, lat_q, 3'h0, en_q};
         else if (reg_addr == `TDS_REG_STATUS)
            reg_rdata <= {16'h0000, 4'(state_q), 2'h0, 2'(list_q), 3'h0, idx_q};
         else if (in_bank(reg_addr, `TDS_REG_DONE_BASE))
            reg_rdata <= done_q[list_of(reg_addr)];
         else if (in_bank(reg_addr, `TDS_REG_SKIP_BASE))
            reg_rdata <= skip_q[list_of(reg_addr)];
         else if (in_bank(reg_addr, `TDS_REG_LAST_BASE))
            reg_rdata <= {27'h0000000, last_q[list_of(reg_addr)]};
         else if (in_bank(reg_addr, `TDS_REG_OR_BASE))
            reg_rdata <= or_q[list_of(reg_addr)];
         else if (in_bank(reg_addr, `TDS_REG_AND_BASE))
            reg_rdata <= and_q[list_of(reg_addr)];
      end
      else
         reg_rdata <= 32'h0000_0000;
   end

endmodule // tds_scheduler

// ==== verification/tds_sched_properties.sv ====
// Concurrent checks on the ports of the descriptor scheduler.
`timescale 1ns/1ps
module tds_sched_properties (
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic [11:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic        xact_start,
   input wire logic [1:0]  xact_list,
   input wire logic        xact_done,
   input wire logic        xact_babble,
   input wire logic        iso_irq,
   input wire logic        sof_irq
);
   logic [11:0] sof_cnt_q;
   logic        sof_seen_q;
   logic [1:0]  list_q;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sof_cnt_q  <= 12'h000;
         sof_seen_q <= 1'b0;
      end
      else
      begin
         sof_cnt_q  <= sof_irq ? 12'h000 : sof_cnt_q + 12'h001;
         sof_seen_q <= sof_seen_q | sof_irq;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset || sof_irq)
         list_q <= 2'h0;
      else if (xact_start)
         list_q <= xact_list;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_RDATA_ONLY_AFTER_READ: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside the answer cycle");
   AST_START_NEEDS_ACTIVE: assert property (xact_start |-> $past(mem_rdata[31]))
      else $error("transaction started for an inactive descriptor");
   AST_START_IS_PULSE: assert property (xact_start |=> !xact_start)
      else $error("transaction start longer than one cycle");
   AST_STATUS_WRITEBACK: assert property (xact_done |=> mem_wr && mem_addr[2:0] == 3'h3)
      else $error("no status write after the transaction");
   AST_ACTIVE_CLEARED: assert property (mem_wr && mem_addr[2:0] == 3'h3 |-> !mem_wdata[31])
      else $error("status write keeps the active flag");
   AST_BABBLE_FLAG: assert property (xact_done && xact_babble |=> mem_wr && mem_wdata[29])
      else $error("babble flag not written");
   AST_BABBLE_VALID: assert property (xact_done && xact_babble |=> ##1
      (mem_wr && mem_addr[2:0] == 3'h0 && !mem_wdata[0]))
      else $error("valid flag not cleared after babble");
   AST_LIST_ORDER: assert property (xact_start |-> xact_list >= list_q)
      else $error("lists taken out of order");
   AST_SOF_PERIOD: assert property (sof_irq && sof_seen_q |-> sof_cnt_q == 12'd3124)
      else $error("microframe tick period wrong");

   COV_XACT: cover property (xact_start);
   COV_BABBLE: cover property (xact_done && xact_babble);
   COV_ISO_IRQ: cover property ($rose(iso_irq));
endmodule // tds_sched_properties

bind tds_scheduler tds_sched_properties chk_u (
   .ref_clk(ref_clk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
   .mem_rdata(mem_rdata), .xact_start(xact_start), .xact_list(xact_list),
   .xact_done(xact_done), .xact_babble(xact_babble), .iso_irq(iso_irq),
   .sof_irq(sof_irq)
);

// ==== verification/tds_far_model.sv ====
// Descriptor memory and transaction engine seen by the scheduler.
`timescale 1ns/1ps
module tds_far_model (
   input  wire logic        ref_clk,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [11:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic      [31:0] mem_rdata,
   input  wire logic        xact_start,
   input  wire logic [1:0]  xact_list,
   input  wire logic [4:0]  xact_index,
   output logic             xact_done,
   output logic             xact_babble,
   input  wire logic [6:0]  babble_sel
);
   logic [31:0] mem [0:4095];
   logic        busy_q;
   logic        bab_q;
   int          wait_q;

   initial
   begin
      mem_rdata   = 32'h0;
      xact_done   = 1'b0;
      xact_babble = 1'b0;
      busy_q      = 1'b0;
   end

   // Read data lasts one cycle, then shows the inverse.
   always @(posedge ref_clk)
   begin
      if (mem_wr)
         mem[mem_addr] <= mem_wdata;
      mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
   end

   // Odd indices answer slowly; the selected descriptor babbles.
   always @(posedge ref_clk)
   begin
      xact_done   <= 1'b0;
      xact_babble <= ~xact_babble;
      if (busy_q)
      begin
         if (wait_q == 0)
         begin
            xact_done   <= 1'b1;
            xact_babble <= bab_q;
            busy_q      <= 1'b0;
         end
         else
            wait_q <= wait_q - 1;
      end
      if (xact_start)
      begin
         busy_q <= 1'b1;
         wait_q <= xact_index[0] ? 20 : 0;
         bab_q  <= ({xact_list, xact_index} == babble_sel);
      end
   end
endmodule // tds_far_model

// ==== verification/transfer_descriptor_scheduler_bench.sv ====
// Self-checking bench for the descriptor scheduler.
`timescale 1ns/1ps
module transfer_descriptor_scheduler_bench;
   logic        ref_clk, reset, reg_wr, reg_rd, mem_rd, mem_wr;
   logic        xact_start, xact_done, xact_babble;
   logic        iso_irq, intl_irq, async_irq, sof_irq;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata;
   logic [11:0] mem_addr;
   logic [1:0]  xact_list;
   logic [4:0]  xact_index;
   logic [6:0]  xlog [$];
   int          err_total, total_checks;

   tds_scheduler dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .xact_start(xact_start), .xact_list(xact_list),
      .xact_index(xact_index), .xact_done(xact_done), .xact_babble(xact_babble),
      .iso_irq(iso_irq), .intl_irq(intl_irq), .async_irq(async_irq), .sof_irq(sof_irq));

   tds_far_model partner_u (.ref_clk(ref_clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .xact_start(xact_start), .xact_list(xact_list), .xact_index(xact_index),
      .xact_done(xact_done), .xact_babble(xact_babble), .babble_sel(7'h20));

   always #20 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
      if (xact_start === 1'b1)
         xlog.push_back({xact_list, xact_index});

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask

   task automatic wait_sof(input int n);
      int c;
      for (int i = 0; i < n; i++)
      begin
         c = 0;
         do
         begin
            @(posedge ref_clk);
            #1 c++;
         end
         while (sof_irq !== 1'b1 && c < 4000);
         if (c >= 4000)
         begin
            err_total++;
            give_verdict();
         end
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic reset_values();
      rd_chk(8'h00, 32'h0000_0010);
      rd_chk(8'h04, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         rd_chk(8'h10 + 8'(i * 4), 32'h0);
         rd_chk(8'h30 + 8'(i * 4), 32'h0000_001f);
         rd_chk(8'h40 + 8'(i * 4), 32'h0);
         rd_chk(8'h50 + 8'(i * 4), 32'h0);
      end
      rd_chk(8'h7c, 32'h0);
   endtask

   task automatic walk_lists();
      int c;
      wr(8'h30, 32'h4);
      wr(8'h34, 32'h0);
      wr(8'h38, 32'h1);
      wr(8'h20, 32'h8);
      wr(8'h40, 32'h1);
      rd_chk(8'h40, 32'h1);
      wr(8'h58, 32'h3);
      wr(8'h00, 32'h11);
      c = 0;
      while (xlog.size() < 5 && c < 9000)
      begin
         @(posedge ref_clk);
         c++;
      end
      if (c >= 9000)
      begin
         err_total++;
         give_verdict();
      end
      check(32'(xlog.size()), 32'd5);
      check(32'(xlog[0]), 32'h00);
      check(32'(xlog[1]), 32'h02);
      check(32'(xlog[2]), 32'h04);
      check(32'(xlog[3]), 32'h20);
      check(32'(xlog[4]), 32'h41);
      wait_sof(2);
      check(32'(xlog.size()), 32'd5);
      check(partner_u.mem[12'h003], 32'h0);
      check(32'(partner_u.mem[12'h00b][31]), 32'h1);
      check(32'(partner_u.mem[12'h103][31:29]), 32'h1);
      check(32'(partner_u.mem[12'h100][0]), 32'h0);
      check(32'(partner_u.mem[12'h000][0]), 32'h1);
      rd_chk(8'h10, 32'h15);
      rd_chk(8'h14, 32'h1);
      rd_chk(8'h18, 32'h2);
   endtask

   task automatic irq_groups();
      check(32'(iso_irq), 32'h1);
      check(32'(intl_irq), 32'h0);
      check(32'(async_irq), 32'h0);
      wr(8'h58, 32'h2);
      wr(8'h44, 32'h1);
      wr(8'h10, 32'h15);
      rd_chk(8'h10, 32'h0);
      wait_sof(2);
      check(32'(iso_irq), 32'h0);
      check(32'(intl_irq), 32'h1);
      check(32'(async_irq), 32'h1);
      wr(8'h00, 32'h21);
      wr(8'h18, 32'h2);
      wait_sof(1);
      check(32'(async_irq), 32'h1);
      wait_sof(1);
      check(32'(async_irq), 32'h0);
   endtask

   initial
   begin
      ref_clk = 1'b0;
      reset = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      err_total = 0;
      total_checks = 0;
      for (int i = 0; i < 4096; i++)
         partner_u.mem[i] = 32'h0;
      for (int i = 0; i < 5; i++)
      begin
         partner_u.mem[i * 8] = 32'h1;
         partner_u.mem[i * 8 + 3] = 32'h8000_0000;
      end
      partner_u.mem[12'h004] = 32'h22;
      partner_u.mem[12'h014] = 32'h21;
      partner_u.mem[12'h01c] = 32'h25;
      partner_u.mem[12'h100] = 32'h1;
      partner_u.mem[12'h103] = 32'h8000_0000;
      partner_u.mem[12'h200] = 32'h1;
      partner_u.mem[12'h204] = 32'h5;
      partner_u.mem[12'h20b] = 32'h8000_0000;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      reset_values();
      walk_lists();
      irq_groups();
      give_verdict();
   end
endmodule // transfer_descriptor_scheduler_bench
